// file: design/pcamc_map.vh
// Purpose: Constants for the counter array mode and PWM cycle configuration
// Assumes: 8-bit special function register bus
// Notes: Definitions only
`ifndef PCAMC_MAP_VH
`define PCAMC_MAP_VH

// Register addresses
`define PCAMC_ADDR_MODE 8'hD9
`define PCAMC_ADDR_PWM 8'hDF

// Mode register fields
`define PCAMC_MD_IDLE 7
`define PCAMC_MD_WATCHDOG_ENABLE 6
`define PCAMC_MD_LOCK 5
`define PCAMC_MD_TB_HI 3
`define PCAMC_MD_TB_LO 1
`define PCAMC_MD_OVFM 0
`define PCAMC_MD_RESET 8'h40

// PWM configuration fields
`define PCAMC_PW_RELOAD_REGISTER_SELECT 7
`define PCAMC_PW_COVM 6
`define PCAMC_PW_CYCLE_OVERFLOW_FLAG 5
`define PCAMC_PW_CL_HI 1
`define PCAMC_PW_CL_LO 0
`define PCAMC_PW_RESET 8'h00

// Timebase codes
`define PCAMC_TB_DIV12 3'h0
`define PCAMC_TB_DIV4 3'h1
`define PCAMC_TB_T0OVF 3'h2
`define PCAMC_TB_EXTIN 3'h3
`define PCAMC_TB_SYSCLK 3'h4
`define PCAMC_TB_EXTOSC 3'h5
`define PCAMC_TB_RTCOSC 3'h6

// Divider terminal counts
`define PCAMC_DIV12_LAST 4'hB
`define PCAMC_DIV4_LAST 2'h3
`define PCAMC_OSCDIV_LAST 3'h7

// Cycle lengths
`define PCAMC_CYC_BASE 5'h08
`define PCAMC_CYC_WIDE 5'h10

`endif

// file: design/pcamc_sync.v
// Purpose: Three-stage synchroniser with edge pulses for an outside input
// Assumes: Input is asynchronous to clk
// Notes: Level changes once stages two and three agree
`timescale 1ns/10ps
`default_nettype none

module pcamc_sync (
    // Clock and reset
    input wire clk,
    input wire rst,
    // Raw input
    input wire din,
    // Filtered level and edges
    output reg level_q,
    output reg rise_q,
    output reg fall_q
);

reg s1_q;
reg s2_q;
reg s3_q;

always @(posedge clk or posedge rst) begin
    if (rst) begin
        s1_q <= 1'b0;
        s2_q <= 1'b0;
        s3_q <= 1'b0;
        level_q <= 1'b0;
        rise_q <= 1'b0;
        fall_q <= 1'b0;
    end else begin
        s1_q <= din;
        s2_q <= s1_q;
        s3_q <= s2_q;
        rise_q <= 1'b0;
        fall_q <= 1'b0;
        if (s2_q == s3_q && s3_q != level_q) begin
            level_q <= s3_q;
            rise_q <= s3_q;
            fall_q <= ~s3_q;
        end
    end
end

endmodule
`default_nettype wire

// file: design/pcamc_top.v
// Purpose: Mode and PWM cycle configuration of a six-module counter array
// Assumes: Counter and module datapaths sit outside; one system clock
// Notes: Register reads answer one clock after the read strobe
// Function
// R1 - Idle suspend bit stops counting during idle
// R2 - Watchdog enable hands module 5 over; resets one
// R3 - Lock blocks watchdog disable until reset
// R4 - Watchdog enabled freezes other mode bits; the lock bit can still be set while enabled
// R5 - Mode bit 4 reads zero, ignores writes
// R6 - Timebase select chooses counter increment source
// R7 - External input falling edges counted, rate limited
// R8 - Codes 101/110 count synced oscillators divided by 8
// R9 - Counter overflow flag with mask raises request
// R10 - Reload select steers compare addresses to reload
// R11 - Reload values used only in 9-11 bit PWM
// R12 - Cycle overflow flag set at selected bit
// R13 - Cycle flag set by hardware/software, software clears
// R14 - Cycle overflow flag with mask raises request
// R15 - PWM config bits 4:2 read zero, ignore writes
// R16 - Cycle select 00/01/10 gives 8/9/10 bits
// R17 - Cycle length for non-wide PWM modules only
// R18 - Cycle select 11 gives 11 bits
// R19 - Counter wrap sets flag; software clears it
// R20 - Wide select picks 16-bit PWM cycle
`timescale 1ns/10ps
`default_nettype none
`include "pcamc_map.vh"

module pcamc_top #(
    parameter NMOD = 6
) (
    // Clock and reset
    input wire CLOCK,
    input wire RST,
    // Register bus
    input wire [7:0] SFR_ADDR,
    input wire SFR_WR,
    input wire [7:0] SFR_WDATA,
    input wire SFR_RD,
    output wire [7:0] SFR_RDATA,
    // CPU state
    input wire CPU_IDLE,
    // Timebase sources
    input wire T0_OVF,
    input wire EXT_COUNT_IN,
    input wire EXT_OSC,
    input wire RTC_OSC,
    // Counter status
    input wire [15:0] COUNT,
    input wire COUNT_STEP,
    input wire CF_CLEAR,
    // Module modes
    input wire [NMOD-1:0] MOD_PWM,
    input wire [NMOD-1:0] WIDE_PWM_SELECT,
    // Outputs to the counter array
    output wire TICK,
    output wire WATCHDOG_ENABLE,
    output wire WATCHDOG_LOCK,
    output wire RELOAD_REGISTER_SELECT,
    output wire [NMOD-1:0] RELOAD_USE,
    output wire [5*NMOD-1:0] MOD_CYCLE_BITS,
    output wire COUNTER_OVERFLOW_FLAG,
    output wire IRQ
);

// Configuration state
reg idle_suspend_q;
reg watchdog_enable_q;
reg watchdog_lock_q;
reg [2:0] timebase_select_q;
reg overflow_irq_mask_q;
reg counter_overflow_flag_q;
reg reload_register_select_q;
reg cycle_overflow_irq_mask_q;
reg cycle_overflow_flag_q;
reg [1:0] cycle_length_select_q;

// Timebase state
reg [3:0] div12_q;
reg [1:0] div4_q;
reg [2:0] extosc_cnt_q;
reg [2:0] rtcosc_cnt_q;
reg tick_q;
reg tick_d;

// Output flops
reg [7:0] rdata_q;
reg irq_q;
reg [NMOD-1:0] reload_use_q;
reg [5*NMOD-1:0] mod_cycle_q;

wire eci_fall;
wire extosc_rise;
wire rtcosc_rise;
wire wr_mode;
wire wr_pwm;
wire cycle_hit;
wire wrap_hit;
wire cf_req;
wire cov_req;
wire [4:0] cyc_len;

// Reset words of the two registers
localparam [7:0] MD_RST = `PCAMC_MD_RESET;
localparam [7:0] PW_RST = `PCAMC_PW_RESET;

// Cycle length in bits for a select code
function [4:0] cycle_bits;
    input [1:0] sel;
    begin
        cycle_bits = `PCAMC_CYC_BASE + {3'h0, sel}; // [R16] [R18]
    end
endfunction

// True when the counter is about to carry out of its low n bits
function carry_out;
    input [15:0] cnt;
    input [4:0] nbits;
    reg [15:0] mask;
    begin
        mask = 16'hFFFF >> (5'h10 - nbits);
        carry_out = ((cnt & mask) == mask);
    end
endfunction

// Synchronisers for outside inputs
pcamc_sync u_sync_eci (
    .clk(CLOCK),
    .rst(RST),
    .din(EXT_COUNT_IN),
    .level_q(),
    .rise_q(),
    .fall_q(eci_fall)
);

pcamc_sync u_sync_extosc (
    .clk(CLOCK),
    .rst(RST),
    .din(EXT_OSC),
    .level_q(),
    .rise_q(extosc_rise),
    .fall_q()
);

pcamc_sync u_sync_rtcosc (
    .clk(CLOCK),
    .rst(RST),
    .din(RTC_OSC),
    .level_q(),
    .rise_q(rtcosc_rise),
    .fall_q()
);

assign wr_mode = SFR_WR && (SFR_ADDR == `PCAMC_ADDR_MODE);
assign wr_pwm = SFR_WR && (SFR_ADDR == `PCAMC_ADDR_PWM);
assign cyc_len = cycle_bits(cycle_length_select_q); // [R16] [R18]
assign cycle_hit = COUNT_STEP && carry_out(COUNT, cyc_len); // [R12]
assign cf_req = counter_overflow_flag_q && overflow_irq_mask_q; // [R9]
assign cov_req = cycle_overflow_flag_q && cycle_overflow_irq_mask_q; // [R14]
assign wrap_hit = COUNT_STEP && (COUNT == 16'hFFFF); // [R19]

// Mode register
always @(posedge CLOCK or posedge RST) begin
    if (RST) begin
        idle_suspend_q <= MD_RST[`PCAMC_MD_IDLE];
        watchdog_enable_q <= MD_RST[`PCAMC_MD_WATCHDOG_ENABLE]; // [R2]
        watchdog_lock_q <= MD_RST[`PCAMC_MD_LOCK];
        timebase_select_q <= MD_RST[`PCAMC_MD_TB_HI:`PCAMC_MD_TB_LO];
        overflow_irq_mask_q <= MD_RST[`PCAMC_MD_OVFM];
    end else if (wr_mode) begin
        if (!watchdog_lock_q) begin
            watchdog_enable_q <= SFR_WDATA[`PCAMC_MD_WATCHDOG_ENABLE] | SFR_WDATA[`PCAMC_MD_LOCK]; // [R3]
        end
        if (SFR_WDATA[`PCAMC_MD_LOCK]) begin
            watchdog_lock_q <= 1'b1; // [R3]
        end
        if (!watchdog_enable_q) begin // [R4]
            idle_suspend_q <= SFR_WDATA[`PCAMC_MD_IDLE];
            timebase_select_q <= SFR_WDATA[`PCAMC_MD_TB_HI:`PCAMC_MD_TB_LO];
            overflow_irq_mask_q <= SFR_WDATA[`PCAMC_MD_OVFM];
        end
    end
end

// PWM configuration register
always @(posedge CLOCK or posedge RST) begin
    if (RST) begin
        reload_register_select_q <= PW_RST[`PCAMC_PW_RELOAD_REGISTER_SELECT];
        cycle_overflow_irq_mask_q <= PW_RST[`PCAMC_PW_COVM];
        cycle_overflow_flag_q <= PW_RST[`PCAMC_PW_CYCLE_OVERFLOW_FLAG];
        cycle_length_select_q <= PW_RST[`PCAMC_PW_CL_HI:`PCAMC_PW_CL_LO];
    end else begin
        if (wr_pwm) begin
            reload_register_select_q <= SFR_WDATA[`PCAMC_PW_RELOAD_REGISTER_SELECT]; // [R10]
            cycle_overflow_irq_mask_q <= SFR_WDATA[`PCAMC_PW_COVM];
            cycle_length_select_q <= SFR_WDATA[`PCAMC_PW_CL_HI:`PCAMC_PW_CL_LO];
            cycle_overflow_flag_q <= SFR_WDATA[`PCAMC_PW_CYCLE_OVERFLOW_FLAG]; // [R13]
        end
        if (cycle_hit) begin
            cycle_overflow_flag_q <= 1'b1; // [R12] [R13]
        end
    end
end

// Counter overflow flag, hardware set wins over clear
always @(posedge CLOCK or posedge RST) begin
    if (RST) begin
        counter_overflow_flag_q <= 1'b0;
    end else if (wrap_hit) begin
        counter_overflow_flag_q <= 1'b1; // [R19]
    end else if (CF_CLEAR) begin
        counter_overflow_flag_q <= 1'b0; // [R19]
    end
end

// Prescalers
always @(posedge CLOCK or posedge RST) begin
    if (RST) begin
        div12_q <= 4'h0;
        div4_q <= 2'h0;
        extosc_cnt_q <= 3'h0;
        rtcosc_cnt_q <= 3'h0;
    end else begin
        div12_q <= (div12_q == `PCAMC_DIV12_LAST) ? 4'h0 : div12_q + 4'h1;
        div4_q <= div4_q + 2'h1;
        if (extosc_rise) begin
            extosc_cnt_q <= extosc_cnt_q + 3'h1; // [R8]
        end
        if (rtcosc_rise) begin
            rtcosc_cnt_q <= rtcosc_cnt_q + 3'h1; // [R8]
        end
    end
end

// Timebase source selection
always @* begin
    case (timebase_select_q) // [R6]
        `PCAMC_TB_DIV12: tick_d = (div12_q == `PCAMC_DIV12_LAST);
        `PCAMC_TB_DIV4: tick_d = (div4_q == `PCAMC_DIV4_LAST);
        `PCAMC_TB_T0OVF: tick_d = T0_OVF;
        `PCAMC_TB_EXTIN: tick_d = eci_fall; // [R7]
        `PCAMC_TB_SYSCLK: tick_d = 1'b1;
        `PCAMC_TB_EXTOSC: tick_d = extosc_rise && (extosc_cnt_q == `PCAMC_OSCDIV_LAST); // [R8]
        `PCAMC_TB_RTCOSC: tick_d = rtcosc_rise && (rtcosc_cnt_q == `PCAMC_OSCDIV_LAST); // [R8]
        default: tick_d = 1'b0;
    endcase
    if (idle_suspend_q && CPU_IDLE) begin
        tick_d = 1'b0; // [R1]
    end
end

// Registered outputs
always @(posedge CLOCK or posedge RST) begin
    if (RST) begin
        tick_q <= 1'b0;
        irq_q <= 1'b0;
        rdata_q <= 8'h00;
    end else begin
        tick_q <= tick_d;
        irq_q <= cf_req || cov_req; // [R9] [R14]
        if (SFR_RD) begin
            case (SFR_ADDR)
                `PCAMC_ADDR_MODE: rdata_q <= {idle_suspend_q, watchdog_enable_q, watchdog_lock_q,
                    1'b0, timebase_select_q, overflow_irq_mask_q}; // [R5]
                `PCAMC_ADDR_PWM: rdata_q <= {reload_register_select_q, cycle_overflow_irq_mask_q,
                    cycle_overflow_flag_q, 3'h0, cycle_length_select_q}; // [R15]
                default: rdata_q <= 8'h00;
            endcase
        end
    end
end

// Per-module cycle length and reload use
genvar gi;
generate
    for (gi = 0; gi < NMOD; gi = gi + 1) begin : g_mod
        always @(posedge CLOCK or posedge RST) begin
            if (RST) begin
                mod_cycle_q[5*gi +: 5] <= `PCAMC_CYC_BASE;
                reload_use_q[gi] <= 1'b0;
            end else begin
                mod_cycle_q[5*gi +: 5] <= WIDE_PWM_SELECT[gi] ? `PCAMC_CYC_WIDE
                    : cyc_len; // [R17] [R20]
                reload_use_q[gi] <= MOD_PWM[gi] && !WIDE_PWM_SELECT[gi]
                    && (cycle_length_select_q != 2'h0); // [R11]
            end
        end
    end
endgenerate

assign SFR_RDATA = rdata_q;
assign TICK = tick_q;
assign WATCHDOG_ENABLE = watchdog_enable_q; // [R2]
assign WATCHDOG_LOCK = watchdog_lock_q;
assign RELOAD_REGISTER_SELECT = reload_register_select_q; // [R10]
assign RELOAD_USE = reload_use_q;
assign MOD_CYCLE_BITS = mod_cycle_q;
assign COUNTER_OVERFLOW_FLAG = counter_overflow_flag_q;
assign IRQ = irq_q;

endmodule
`default_nettype wire

// file: verification/pcamc_asserts.sv
// Purpose: Port checks for the mode and cycle configuration block
// Assumes: One clock, reset active high
// Notes: Reads answer one clock after the strobe
`timescale 1ns/10ps
`default_nettype none
module pcamc_asserts #(
    parameter NMOD = 6
) (
    // Clock and reset
    input wire logic CLOCK,
    input wire logic RST,
    // Register bus
    input wire logic [7:0] SFR_ADDR,
    input wire logic SFR_WR,
    input wire logic [7:0] SFR_WDATA,
    input wire logic SFR_RD,
    input wire logic [7:0] SFR_RDATA,
    // Module modes
    input wire logic [NMOD-1:0] MOD_PWM,
    input wire logic [NMOD-1:0] WIDE_PWM_SELECT,
    // Results
    input wire logic WATCHDOG_ENABLE,
    input wire logic WATCHDOG_LOCK,
    input wire logic RELOAD_REGISTER_SELECT,
    input wire logic [NMOD-1:0] RELOAD_USE,
    input wire logic [5*NMOD-1:0] MOD_CYCLE_BITS
);
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (RST);

    wdog_reset_a: assert property ($fell(RST) |-> WATCHDOG_ENABLE && !WATCHDOG_LOCK)
        else $error("watchdog not on after reset");
    wdog_clear_a: assert property (SFR_WR && SFR_ADDR == 8'hD9 && SFR_WDATA[6:5] == 2'h0 && !WATCHDOG_LOCK
        |=> !WATCHDOG_ENABLE) else $error("watchdog not cleared");
    lock_set_a: assert property (SFR_WR && SFR_ADDR == 8'hD9 && SFR_WDATA[5]
        |=> WATCHDOG_LOCK && WATCHDOG_ENABLE) else $error("lock not set");
    lock_sticky_a: assert property (WATCHDOG_LOCK |=> WATCHDOG_LOCK && WATCHDOG_ENABLE)
        else $error("locked watchdog dropped");
    mode_bit4_a: assert property (SFR_RD && SFR_ADDR == 8'hD9
        |=> !SFR_RDATA[4] && SFR_RDATA[6] == $past(WATCHDOG_ENABLE)) else $error("mode read wrong");
    pwm_unused_a: assert property (SFR_RD && SFR_ADDR == 8'hDF
        |=> SFR_RDATA[4:2] == 3'h0 && SFR_RDATA[7] == $past(RELOAD_REGISTER_SELECT)) else $error("pwm read wrong");
    reload_sel_a: assert property (SFR_WR && SFR_ADDR == 8'hDF
        |=> RELOAD_REGISTER_SELECT == $past(SFR_WDATA[7])) else $error("reload select wrong");
    wide_cycle_a: assert property (MOD_PWM[0] && WIDE_PWM_SELECT[0]
        |=> MOD_CYCLE_BITS[4:0] == 5'h10 && !RELOAD_USE[0]) else $error("wide cycle wrong");
endmodule

bind pcamc_top pcamc_asserts #(.NMOD(NMOD)) u_chk (
    .CLOCK(CLOCK), .RST(RST), .SFR_ADDR(SFR_ADDR), .SFR_WR(SFR_WR), .SFR_WDATA(SFR_WDATA),
    .SFR_RD(SFR_RD), .SFR_RDATA(SFR_RDATA), .MOD_PWM(MOD_PWM), .WIDE_PWM_SELECT(WIDE_PWM_SELECT),
    .WATCHDOG_ENABLE(WATCHDOG_ENABLE), .WATCHDOG_LOCK(WATCHDOG_LOCK),
    .RELOAD_REGISTER_SELECT(RELOAD_REGISTER_SELECT), .RELOAD_USE(RELOAD_USE), .MOD_CYCLE_BITS(MOD_CYCLE_BITS)
);
`default_nettype wire

// file: verification/tb_pcamc_top.sv
// Purpose: Self-checking bench for the mode and cycle configuration block
// Assumes: Inputs change 2 ns after the rising edge
// Notes: Tick windows span whole prescaler periods
`timescale 1ns/10ps
`default_nettype none
module tb_pcamc_top;
    logic CLOCK = 0, RST = 1, SFR_WR = 0, SFR_RD = 0, CPU_IDLE = 0, T0_OVF = 0, EXT_COUNT_IN = 1;
    logic EXT_OSC = 0, RTC_OSC = 0, COUNT_STEP = 0, CF_CLEAR = 0;
    logic [7:0] SFR_ADDR = 8'h00, SFR_WDATA = 8'h00, rdata;
    logic [15:0] COUNT = 16'h0000;
    logic [5:0] MOD_PWM = 6'h00, WIDE_PWM_SELECT = 6'h00;
    logic [31:0] r = 32'h0087;
    wire [7:0] SFR_RDATA;
    wire [5:0] RELOAD_USE;
    wire [29:0] MOD_CYCLE_BITS;
    wire TICK, WATCHDOG_ENABLE, WATCHDOG_LOCK, RELOAD_REGISTER_SELECT, COUNTER_OVERFLOW_FLAG, IRQ;
    int failures = 0, num_checks = 0, n, e;
    logic [7:0] mode_t [9] = '{8'h00, 8'h02, 8'h04, 8'h06, 8'h08, 8'h0A, 8'h0C, 8'h0E, 8'h88};
    int exp_t [9] = '{16, 48, 0, 20, 192, 5, 5, 0, 0};

    pcamc_top #(.NMOD(6)) dut (
        .CLOCK(CLOCK), .RST(RST), .SFR_ADDR(SFR_ADDR), .SFR_WR(SFR_WR), .SFR_WDATA(SFR_WDATA),
        .SFR_RD(SFR_RD), .SFR_RDATA(SFR_RDATA), .CPU_IDLE(CPU_IDLE), .T0_OVF(T0_OVF),
        .EXT_COUNT_IN(EXT_COUNT_IN), .EXT_OSC(EXT_OSC), .RTC_OSC(RTC_OSC), .COUNT(COUNT),
        .COUNT_STEP(COUNT_STEP), .CF_CLEAR(CF_CLEAR), .MOD_PWM(MOD_PWM), .WIDE_PWM_SELECT(WIDE_PWM_SELECT),
        .TICK(TICK), .WATCHDOG_ENABLE(WATCHDOG_ENABLE), .WATCHDOG_LOCK(WATCHDOG_LOCK),
        .RELOAD_REGISTER_SELECT(RELOAD_REGISTER_SELECT), .RELOAD_USE(RELOAD_USE),
        .MOD_CYCLE_BITS(MOD_CYCLE_BITS), .COUNTER_OVERFLOW_FLAG(COUNTER_OVERFLOW_FLAG), .IRQ(IRQ)
    );

    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    function automatic logic [4:0] cyc_bits(input logic wide, input logic [1:0] s);
        return wide ? 5'h10 : 5'h08 + {3'h0, s};
    endfunction
    task automatic chk(input logic [15:0] seen, input logic [15:0] want);
        num_checks++;
        if (seen !== want) begin
            failures++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, want);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge CLOCK);
        #2 SFR_WR = 1;
        SFR_ADDR = a;
        SFR_WDATA = d;
        @(posedge CLOCK);
        #2 SFR_WR = 0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge CLOCK);
        #2 SFR_RD = 1;
        SFR_ADDR = a;
        @(posedge CLOCK);
        #2 SFR_RD = 0;
        rdata = SFR_RDATA;
    endtask
    task automatic step(input logic [15:0] c);
        @(posedge CLOCK);
        #2 COUNT = c;
        COUNT_STEP = 1;
        @(posedge CLOCK);
        #2 COUNT_STEP = 0;
    endtask
    task automatic stop_test;
        $display("checks=%0d failures=%0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial forever #12.5 CLOCK = ~CLOCK;
    initial begin
        repeat (100000) @(posedge CLOCK);
        failures++;
        stop_test;
    end

    initial begin
        repeat (6) @(posedge CLOCK);
        #2 RST = 0;
        rd(8'hD9);
        chk(rdata, 8'h40);
        rd(8'hDF);
        chk(rdata, 8'h00);
        wr(8'hD9, 8'h9F);
        rd(8'hD9);
        chk(rdata, 8'h00);
        wr(8'hD9, 8'h9F);
        rd(8'hD9);
        chk(rdata, 8'h8F);
        for (int k = 0; k < 9; k++) begin
            wr(8'hD9, mode_t[k]);
            repeat (2) @(posedge CLOCK);
            n = 0;
            e = exp_t[k];
            for (int i = 0; i < 192; i++) begin
                @(posedge CLOCK);
                #2 n += (TICK === 1'b1);
                r = lfsr(r);
                T0_OVF = (i < 160) & r[0];
                e += (k == 2) & T0_OVF;
                CPU_IDLE = mode_t[k][7] | r[1] | (i >= 188);
                EXT_COUNT_IN = (i >= 160) | ~i[2];
                EXT_OSC = (i < 160) & i[1];
                RTC_OSC = EXT_OSC;
            end
            chk(n, e);
        end
        for (int s = 0; s < 4; s++) begin
            r = lfsr(r);
            MOD_PWM = {5'h1F, s[1]};
            WIDE_PWM_SELECT = {r[4:0], s[0]};
            wr(8'hDF, {6'h10, s[1:0]});
            step(16'hFFFF >> (9 - s));
            rd(8'hDF);
            chk(rdata, {6'h10, s[1:0]});
            step(16'hFFFF >> (8 - s));
            rd(8'hDF);
            chk(rdata, {6'h18, s[1:0]});
            chk(IRQ, 1'b1);
            chk(RELOAD_USE, MOD_PWM & ~WIDE_PWM_SELECT & {6{s != 0}});
            for (int m = 0; m < 6; m++) chk(MOD_CYCLE_BITS[5*m+:5], cyc_bits(WIDE_PWM_SELECT[m], s[1:0]));
        end
        wr(8'hDF, 8'h00);
        repeat (2) @(posedge CLOCK);
        #2 chk(IRQ, 1'b0);
        wr(8'hDF, 8'hBC);
        rd(8'hDF);
        chk(rdata, 8'hA0);
        chk({RELOAD_REGISTER_SELECT, IRQ}, 2'b10);
        wr(8'hDF, 8'h00);
        wr(8'hD9, 8'h01);
        step(16'hFFFF);
        chk({COUNTER_OVERFLOW_FLAG, IRQ}, 2'b10);
        @(posedge CLOCK);
        #2 chk(IRQ, 1'b1);
        CF_CLEAR = 1;
        @(posedge CLOCK);
        #2 CF_CLEAR = 0;
        chk(COUNTER_OVERFLOW_FLAG, 1'b0);
        wr(8'hD9, 8'h20);
        wr(8'hD9, 8'h00);
        rd(8'hD9);
        chk(rdata, 8'h60);
        chk({WATCHDOG_ENABLE, WATCHDOG_LOCK}, 2'b11);
        step(16'hFFFF);
        @(posedge CLOCK);
        #2 chk({COUNTER_OVERFLOW_FLAG, IRQ}, 2'b10);
        rd(8'h55);
        chk(rdata, 8'h00);
        stop_test;
    end
endmodule
`default_nettype wire
